//--- pixel_port_mux.sv
// How it works
// - Mode decoding uses mux control bits 5 down to 0, ignoring bits 7 and 6.
// - Codes 18h-1Bh give 4-bit pixels, 1Ch-1Eh give 8-bit pixels.
// - Code 1Fh is nibble mode: four 4-bit pixels from 32 pins.
// - Nibble flag low takes low nibbles of each byte, high takes upper.
// - Modes 0 to 3 give palette addresses, mode 4 gives DAC data.
// - Groups per bus load equal the shift-clock divide ratio; here they follow the mux code, and status bit 7 shows a match.
// - A shift-clock rising edge captures the whole bus load at once.
// - Groups leave on the dot clock, lowest-numbered group first.
// - True colour sends bits 31:24 blue, 23:16 green, 15:8 red.
// - Bits 7:0 are overlay, off when zero or the read mask is clear.
// - After reset the block runs VGA pass-through.
// - Selecting pass-through restores clock select, control and mask.
// - Pass-through takes bit-plane data from the separate VGA bus.
// - Pass-through timing follows the first oscillator input.
// - Other modes capture on the shift clock and emit on the dot clock.
// - Nibble bit set and split transfer clear force nibble mode.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pixel_port_mux (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        SHIFT_CLK_I,
   input  wire logic        DOT_CLK_I,
   input  wire logic        OSC_ZERO_I,
   input  wire logic        NIBBLE_FLAG_I,
   input  wire logic [31:0] PIXEL_PORT_I,
   input  wire logic [7:0]  VGA_PORT_I,
   output logic             PIX_VALID_O,
   output logic      [7:0]  PAL_ADDR_O,
   output logic             DIRECT_O,
   output logic      [7:0]  RED_O,
   output logic      [7:0]  GREEN_O,
   output logic      [7:0]  BLUE_O,
   output logic             OVL_EN_O,
   output logic      [7:0]  OVL_ADDR_O
);

   localparam int PIN_W = 44;

   // Decodes a mux code and the general control byte into a mode.
   function automatic pixmux_pkg::mode_info_t decode_mode(
      input logic [7:0] mux,
      input logic [7:0] gen
   );
      pixmux_pkg::mode_info_t mi;
      logic [5:0]             code;
      mi   = '{mode: pixmux_pkg::MODE_NONE, groups: 4'h0, gbits: 6'h00};
      code = mux[pixmux_pkg::MUX_SEL_MSB:0];
      case (code)
         pixmux_pkg::CODE_VGA: begin
            mi = '{mode: pixmux_pkg::MODE_VGA, groups: 4'h1, gbits: 6'h08};
         end
         pixmux_pkg::CODE_P4_4: begin
            mi = '{mode: pixmux_pkg::MODE_PAL4, groups: 4'h1, gbits: 6'h04};
         end
         pixmux_pkg::CODE_P4_8: begin
            mi = '{mode: pixmux_pkg::MODE_PAL4, groups: 4'h2, gbits: 6'h04};
         end
         pixmux_pkg::CODE_P4_16: begin
            mi = '{mode: pixmux_pkg::MODE_PAL4, groups: 4'h4, gbits: 6'h04};
         end
         pixmux_pkg::CODE_P4_32: begin
            mi = '{mode: pixmux_pkg::MODE_PAL4, groups: 4'h8, gbits: 6'h04};
         end
         pixmux_pkg::CODE_P8_8: begin
            mi = '{mode: pixmux_pkg::MODE_PAL8, groups: 4'h1, gbits: 6'h08};
         end
         pixmux_pkg::CODE_P8_16: begin
            mi = '{mode: pixmux_pkg::MODE_PAL8, groups: 4'h2, gbits: 6'h08};
         end
         pixmux_pkg::CODE_P8_32: begin
            mi = '{mode: pixmux_pkg::MODE_PAL8, groups: 4'h4, gbits: 6'h08};
         end
         pixmux_pkg::CODE_NIBBLE: begin
            mi = '{mode: pixmux_pkg::MODE_NIBBLE, groups: 4'h4,
                   gbits: 6'h04};
         end
         pixmux_pkg::CODE_TC_E, pixmux_pkg::CODE_TC_F: begin
            mi = '{mode: pixmux_pkg::MODE_TRUE, groups: 4'h1, gbits: 6'h20};
         end
         default: begin
            mi = '{mode: pixmux_pkg::MODE_NONE, groups: 4'h0,
                   gbits: 6'h00};
         end
      endcase
      // Nibble mode from general control overrides the mux setting.
      if (gen[pixmux_pkg::GEN_NIBBLE_BIT] &&
          !gen[pixmux_pkg::GEN_SPLIT_BIT]) begin
         mi = '{mode: pixmux_pkg::MODE_NIBBLE, groups: 4'h4, gbits: 6'h04};
      end
      return mi;
   endfunction

   logic [PIN_W-1:0]       pin_lvl;
   logic [PIN_W-1:0]       pin_rise;
   logic [31:0]            port_s;
   logic [7:0]             vga_s;
   logic                   shift_rise;
   logic                   dot_rise;
   logic                   osc_rise;
   logic                   nibble_select_flag_s;

   logic [7:0]             mux_r;
   logic [7:0]             mux_nxt;
   logic [7:0]             gen_r;
   logic [7:0]             gen_nxt;
   logic [7:0]             clksel_r;
   logic [7:0]             clksel_nxt;
   logic [7:0]             mask_r;
   logic [7:0]             mask_nxt;
   logic [31:0]            rdata_r;
   logic [31:0]            rdata_nxt;
   logic                   err_r;
   logic                   err_nxt;

   logic [31:0]            load_r;
   logic [31:0]            load_nxt;
   logic [3:0]             left_r;
   logic [3:0]             left_nxt;
   pixmux_pkg::mode_t      mode_q_r;
   pixmux_pkg::mode_t      mode_q_nxt;
   pixmux_pkg::pix_out_t   out_r;
   pixmux_pkg::pix_out_t   out_nxt;

   pixmux_pkg::mode_info_t mi;
   logic                   ratio_ok;
   logic                   wr_en;
   logic                   setup;
   logic [31:0]            nib_load;

   // All pins pass one synchroniser so data and clocks keep equal delay.
   pin_sync #(
      .W (PIN_W)
   ) pin_sync_inst (
      .clk_i  (CLK_SYS_I),
      .rst_i  (RST_I),
      .pin_i  ({VGA_PORT_I, PIXEL_PORT_I, NIBBLE_FLAG_I, OSC_ZERO_I,
                DOT_CLK_I, SHIFT_CLK_I}),
      .lvl_o  (pin_lvl),
      .rise_o (pin_rise)
   );

   // Split the synchronised pins back into their roles.
   assign shift_rise = pin_rise[0];
   assign dot_rise   = pin_rise[1];
   assign osc_rise   = pin_rise[2];
   assign nibble_select_flag_s    = pin_lvl[3];
   assign port_s     = pin_lvl[35:4];
   assign vga_s      = pin_lvl[43:36];

   // Current mode and the divide-ratio consistency check.
   assign mi       = decode_mode(mux_r, gen_r);
   assign ratio_ok = (clksel_r[pixmux_pkg::RATIO_MSB:0] ==
                      {2'b00, mi.groups});

   assign setup = PSEL_I && !PENABLE_I;
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;

   // Register writes, and read data prepared during the setup phase.
   always_comb begin
      mux_nxt    = mux_r;
      gen_nxt    = gen_r;
      clksel_nxt = clksel_r;
      mask_nxt   = mask_r;
      rdata_nxt  = rdata_r;
      err_nxt    = err_r;
      if (wr_en) begin
         case (PADDR_I)
            pixmux_pkg::ADDR_MUX: begin
               mux_nxt = PWDATA_I[7:0];
               // Choosing pass-through restores the companion registers.
               if (PWDATA_I[pixmux_pkg::MUX_SEL_MSB:0] ==
                   pixmux_pkg::CODE_VGA) begin
                  gen_nxt    = pixmux_pkg::GEN_RST;
                  clksel_nxt = pixmux_pkg::CLKSEL_RST;
                  mask_nxt   = pixmux_pkg::MASK_RST;
               end
            end
            pixmux_pkg::ADDR_GEN: begin
               gen_nxt = PWDATA_I[7:0];
            end
            pixmux_pkg::ADDR_CLKSEL: begin
               clksel_nxt = PWDATA_I[7:0];
            end
            pixmux_pkg::ADDR_MASK: begin
               mask_nxt = PWDATA_I[7:0];
            end
            default: begin
               mux_nxt = mux_r;
            end
         endcase
      end
      if (setup) begin
         rdata_nxt = 32'h0000_0000;
         err_nxt   = 1'b0;
         case (PADDR_I)
            pixmux_pkg::ADDR_MUX: begin
               rdata_nxt[7:0] = mux_r;
            end
            pixmux_pkg::ADDR_GEN: begin
               rdata_nxt[7:0] = gen_r;
            end
            pixmux_pkg::ADDR_CLKSEL: begin
               rdata_nxt[7:0] = clksel_r;
            end
            pixmux_pkg::ADDR_MASK: begin
               rdata_nxt[7:0] = mask_r;
            end
            pixmux_pkg::ADDR_STAT: begin
               rdata_nxt[pixmux_pkg::STAT_MODE_LSB +: 3] = mi.mode;
               rdata_nxt[pixmux_pkg::STAT_GRP_LSB +: 4]  = mi.groups;
               rdata_nxt[pixmux_pkg::STAT_OK_BIT]        = ratio_ok;
               rdata_nxt[pixmux_pkg::STAT_LEFT_LSB +: 4] = left_r;
            end
            default: begin
               err_nxt = 1'b1;
            end
         endcase
      end
   end

   // Register file; reset lands in pass-through.
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         mux_r    <= pixmux_pkg::MUX_RST;
         gen_r    <= pixmux_pkg::GEN_RST;
         clksel_r <= pixmux_pkg::CLKSEL_RST;
         mask_r   <= pixmux_pkg::MASK_RST;
         rdata_r  <= 32'h0000_0000;
         err_r    <= 1'b0;
      end else begin
         mux_r    <= mux_nxt;
         gen_r    <= gen_nxt;
         clksel_r <= clksel_nxt;
         mask_r   <= mask_nxt;
         rdata_r  <= rdata_nxt;
         err_r    <= err_nxt;
      end
   end

   // Every transfer completes in its first access cycle.
   assign PREADY_O  = PSEL_I && PENABLE_I;
   assign PSLVERR_O = PSEL_I && PENABLE_I && err_r;
   assign PRDATA_O  = rdata_r;

   // Nibble mode packs one nibble of each byte into a 16-bit load.
   always_comb begin
      nib_load = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         nib_load[4*b +: 4] = nibble_select_flag_s ? port_s[8*b+4 +: 4]
                                      : port_s[8*b +: 4];
      end
   end

   // Capture on the shift clock, emit on the dot clock.
   always_comb begin
      load_nxt          = load_r;
      left_nxt          = left_r;
      mode_q_nxt        = mi.mode;
      out_nxt           = out_r;
      out_nxt.valid     = 1'b0;
      if (mi.mode != mode_q_r) begin
         // A mode change drops whatever was left of the old load.
         left_nxt = 4'h0;
      end else if (mi.mode == pixmux_pkg::MODE_VGA) begin
         // Pass-through is clocked by the first oscillator input.
         left_nxt = 4'h0;
         if (osc_rise) begin
            out_nxt.valid  = 1'b1;
            out_nxt.direct = 1'b0;
            out_nxt.ovl_en = 1'b0;
            out_nxt.pal    = vga_s & mask_r;
         end
      end else if (mi.mode != pixmux_pkg::MODE_NONE) begin
         if (shift_rise) begin
            // The lines above the bus width are ignored here.
            load_nxt = (mi.mode == pixmux_pkg::MODE_NIBBLE) ? nib_load
                                                            : port_s;
            left_nxt = mi.groups;
         end else if (dot_rise && (left_r != 4'h0)) begin
            out_nxt.valid = 1'b1;
            if (mi.mode == pixmux_pkg::MODE_TRUE) begin
               out_nxt.direct = 1'b1;
               out_nxt.blue   = load_r[31:24];
               out_nxt.green  = load_r[23:16];
               out_nxt.red    = load_r[15:8];
               out_nxt.ovl    = load_r[7:0] & mask_r;
               out_nxt.ovl_en = (load_r[7:0] != 8'h00) &&
                                (mask_r != 8'h00);
            end else begin
               out_nxt.direct = 1'b0;
               out_nxt.ovl_en = 1'b0;
               out_nxt.pal    = (mi.gbits == 6'h04)
                                ? {4'h0, load_r[3:0] & mask_r[3:0]}
                                : load_r[7:0] & mask_r;
            end
            // Lowest group leaves first; the rest slide down.
            load_nxt = load_r >> mi.gbits;
            left_nxt = left_r - 4'h1;
         end
      end else begin
         left_nxt = 4'h0;
      end
   end

   // Pixel pipeline registers.
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         load_r   <= 32'h0000_0000;
         left_r   <= 4'h0;
         mode_q_r <= pixmux_pkg::MODE_VGA;
         out_r    <= '0;
      end else begin
         load_r   <= load_nxt;
         left_r   <= left_nxt;
         mode_q_r <= mode_q_nxt;
         out_r    <= out_nxt;
      end
   end

   // Pixel outputs come straight from the pipeline flops.
   assign PIX_VALID_O = out_r.valid;
   assign PAL_ADDR_O  = out_r.pal;
   assign DIRECT_O    = out_r.direct;
   assign RED_O       = out_r.red;
   assign GREEN_O     = out_r.green;
   assign BLUE_O      = out_r.blue;
   assign OVL_EN_O    = out_r.ovl_en;
   assign OVL_ADDR_O  = out_r.ovl;

endmodule
`default_nettype wire

//--- pixmux_pkg.sv
`default_nettype none
package pixmux_pkg;

   // Register byte offsets on the APB.
   localparam logic [7:0] ADDR_MUX    = 8'h00;
   localparam logic [7:0] ADDR_GEN    = 8'h04;
   localparam logic [7:0] ADDR_CLKSEL = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0C;
   localparam logic [7:0] ADDR_STAT   = 8'h10;

   // Reset values of the writable registers.
   localparam logic [7:0] MUX_RST    = 8'h2D;
   localparam logic [7:0] GEN_RST    = 8'h00;
   localparam logic [7:0] CLKSEL_RST = 8'h01;
   localparam logic [7:0] MASK_RST   = 8'hFF;

   // Field positions.
   localparam int GEN_NIBBLE_BIT = 3;
   localparam int GEN_SPLIT_BIT  = 2;
   localparam int MUX_SEL_MSB    = 5;
   localparam int RATIO_MSB      = 5;
   localparam int STAT_MODE_LSB  = 0;
   localparam int STAT_GRP_LSB   = 3;
   localparam int STAT_OK_BIT    = 7;
   localparam int STAT_LEFT_LSB  = 8;

   // Mux control selection codes, bits 5 down to 0.
   localparam logic [5:0] CODE_VGA    = 6'h2D;
   localparam logic [5:0] CODE_P4_4   = 6'h18;
   localparam logic [5:0] CODE_P4_8   = 6'h19;
   localparam logic [5:0] CODE_P4_16  = 6'h1A;
   localparam logic [5:0] CODE_P4_32  = 6'h1B;
   localparam logic [5:0] CODE_P8_8   = 6'h1C;
   localparam logic [5:0] CODE_P8_16  = 6'h1D;
   localparam logic [5:0] CODE_P8_32  = 6'h1E;
   localparam logic [5:0] CODE_NIBBLE = 6'h1F;
   localparam logic [5:0] CODE_TC_E   = 6'h0E;
   localparam logic [5:0] CODE_TC_F   = 6'h0D;

   // Synchroniser depth for pin inputs.
   localparam int SYNC_STAGES = 3;

   typedef enum logic [2:0] {
      MODE_VGA,
      MODE_PAL4,
      MODE_PAL8,
      MODE_NIBBLE,
      MODE_TRUE,
      MODE_NONE
   } mode_t;

   // Decoded operating mode: groups per load and bits per group.
   typedef struct packed {
      mode_t      mode;
      logic [3:0] groups;
      logic [5:0] gbits;
   } mode_info_t;

   // One displayed pixel as handed to the palette or the DACs.
   typedef struct packed {
      logic       valid;
      logic [7:0] pal;
      logic       direct;
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
      logic       ovl_en;
      logic [7:0] ovl;
   } pix_out_t;

endpackage
`default_nettype wire

//--- pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Three-stage pin synchroniser; a change counts once stages two and three
// agree, and a rising edge of the agreed level is reported for one cycle.
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] lvl_o,
   output logic      [W-1:0] rise_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] lvl_nxt;
   logic [W-1:0] rise_r;
   logic [W-1:0] rise_nxt;

   // The agreed level follows only bits whose last two stages match.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
      end
      rise_nxt = lvl_nxt & ~lvl_r;
   end

   // Stage one feeds only stage two.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         lvl_r  <= '0;
         rise_r <= '0;
      end else begin
         s1_r   <= pin_i;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         lvl_r  <= lvl_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign lvl_o  = lvl_r;
   assign rise_o = rise_r;

endmodule
`default_nettype wire

//--- pixel_port_mux_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the pixel multiplexer and its register bus.
module pixel_port_mux_asserts (
   input wire logic        CLK_SYS_I,
   input wire logic        RST_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [7:0]  PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        DOT_CLK_I,
   input wire logic        OSC_ZERO_I,
   input wire logic        PIX_VALID_O,
   input wire logic [7:0]  PAL_ADDR_O,
   input wire logic        DIRECT_O,
   input wire logic [7:0]  RED_O,
   input wire logic [7:0]  GREEN_O,
   input wire logic [7:0]  BLUE_O,
   input wire logic        OVL_EN_O,
   input wire logic [7:0]  OVL_ADDR_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   logic        acc;
   logic        mapped;
   logic        pin_hi;
   logic [41:0] outs;
   // Helper terms for the access phase, address map and pixel outputs.
   assign acc = PSEL_I && PENABLE_I;
   assign mapped = PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
   assign pin_hi = DOT_CLK_I || OSC_ZERO_I;
   assign outs = {PAL_ADDR_O, DIRECT_O, RED_O, GREEN_O, BLUE_O, OVL_EN_O,
                  OVL_ADDR_O};
   property p_ready;
      acc |-> PREADY_O;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   property p_err_unmapped;
      acc && !mapped |-> PSLVERR_O;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");
   property p_err_mapped;
      acc && mapped |-> !PSLVERR_O;
   endproperty
   a_err_mapped: assert property (p_err_mapped) else $error("stray pslverr");
   property p_rd_zero;
      acc && !PWRITE_I && !mapped |-> PRDATA_O == 32'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unmapped read data");
   property p_rd_upper;
      acc && !PWRITE_I |-> PRDATA_O[31:12] == 20'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
   property p_pulse;
      PIX_VALID_O |=> !PIX_VALID_O;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long pixel pulse");
   property p_hold;
      !PIX_VALID_O |-> $stable(outs);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved");
   property p_ovl_tc;
      PIX_VALID_O && OVL_EN_O |-> DIRECT_O;
   endproperty
   a_ovl_tc: assert property (p_ovl_tc) else $error("stray overlay");
   property p_cause;
      PIX_VALID_O |-> $past(pin_hi, 4) || $past(pin_hi, 5) || $past(pin_hi, 6);
   endproperty
   a_cause: assert property (p_cause) else $error("uncaused pixel");
   property p_reset;
      disable iff (1'b0) RST_I |=> !PIX_VALID_O && PRDATA_O == 32'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
   c_pal: cover property (PIX_VALID_O && !DIRECT_O);
   c_direct: cover property (PIX_VALID_O && DIRECT_O && OVL_EN_O);
   c_err: cover property (acc && PSLVERR_O);
endmodule
bind pixel_port_mux pixel_port_mux_asserts pixel_port_mux_asserts_inst (
   .CLK_SYS_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O,
   .PREADY_O, .PSLVERR_O, .DOT_CLK_I, .OSC_ZERO_I, .PIX_VALID_O, .PAL_ADDR_O,
   .DIRECT_O, .RED_O, .GREEN_O, .BLUE_O, .OVL_EN_O, .OVL_ADDR_O);
`default_nettype wire

//--- pixel_source.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural frame buffer and feature connector driving the pixel pins.
module pixel_source (
   input  wire logic        clk_i,
   output logic             shift_o,
   output logic             dot_o,
   output logic             osc_o,
   output logic             flag_o,
   output logic      [31:0] port_o,
   output logic      [7:0]  vga_o
);
   // Clocks idle low; data lines start with a marker pattern.
   initial begin
      shift_o = 1'b0;
      dot_o = 1'b0;
      osc_o = 1'b0;
      flag_o = 1'b0;
      port_o = 32'hDEADBEEF;
      vga_o = 8'hC3;
   end
   // Waits a number of system clock edges.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Latches one load, then gives dots pixel clocks spaced by gap.
   task automatic load(input logic [31:0] d, input logic f, input int dots,
                       input int gap);
      port_o <= d;
      flag_o <= f;
      tick(4);
      shift_o <= 1'b1;
      tick(4);
      shift_o <= 1'b0;
      tick(4);
      port_o <= ~d;
      repeat (dots) begin
         dot_o <= 1'b1;
         tick(gap);
         dot_o <= 1'b0;
         tick(gap);
      end
      tick(4);
   endtask
   // Presents one pass-through byte and clocks it with the oscillator.
   task automatic vga(input logic [7:0] v);
      vga_o <= v;
      tick(4);
      osc_o <= 1'b1;
      tick(4);
      osc_o <= 1'b0;
      tick(4);
      vga_o <= ~v;
      tick(4);
   endtask
endmodule
`default_nettype wire

//--- pixel_port_mux_test.sv
`timescale 1ns/10ps
`default_nettype none
module pixel_port_mux_test;
   logic                 clk;
   logic                 rst;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 shift;
   logic                 dot;
   logic                 osc;
   logic                 flag;
   logic [31:0]          port;
   logic [7:0]           vga;
   logic [31:0]          r;
   logic                 e;
   wire pixmux_pkg::pix_out_t pix;
   pixmux_pkg::pix_out_t seen[$];
   int                   err_count;
   int                   check_count;
   pixel_port_mux pixel_port_mux_inst (.CLK_SYS_I(clk), .RST_I(rst),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .SHIFT_CLK_I(shift), .DOT_CLK_I(dot),
      .OSC_ZERO_I(osc), .NIBBLE_FLAG_I(flag), .PIXEL_PORT_I(port),
      .VGA_PORT_I(vga), .PIX_VALID_O(pix.valid), .PAL_ADDR_O(pix.pal),
      .DIRECT_O(pix.direct), .RED_O(pix.red), .GREEN_O(pix.green),
      .BLUE_O(pix.blue), .OVL_EN_O(pix.ovl_en), .OVL_ADDR_O(pix.ovl));
   pixel_source pixel_source_inst (.clk_i(clk), .shift_o(shift), .dot_o(dot),
      .osc_o(osc), .flag_o(flag), .port_o(port), .vga_o(vga));
   // Clock and collection of every emitted pixel.
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (pix.valid === 1'b1) seen.push_back(pix);
   end
   // Compares one value and counts the result.
   task automatic chk(input string what, input logic [63:0] x,
                      input logic [63:0] g);
      check_count++;
      if (g !== x) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, x, g);
      end
   endtask
   // One APB transfer; waits for pready under a bound.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) chk("pready", 1, 0);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), x, r);
   endtask
   // Checks the palette sequence of the collected pixels.
   task automatic pal_seq(input logic [31:0] d, input int n, input int b);
      chk("count", n, seen.size());
      for (int k = 0; k < n && k < seen.size(); k++) begin
         chk("pal", (d >> (k * b)) & ((32'h1 << b) - 1), seen[k].pal);
         chk("direct", 0, seen[k].direct);
      end
      seen.delete();
   endtask
   task automatic t_reset;
      rd(pixmux_pkg::ADDR_MUX, 32'h2D);
      rd(pixmux_pkg::ADDR_CLKSEL, 32'h01);
      rd(pixmux_pkg::ADDR_GEN, 32'h00);
      rd(pixmux_pkg::ADDR_MASK, 32'hFF);
      rd(pixmux_pkg::ADDR_STAT, 32'h88);
      apb(1'b0, 8'h14, 32'h0);
      chk("slverr", 1, e);
      chk("unmapped", 0, r);
      apb(1'b1, 8'h18, 32'hFF);
      chk("slverr", 1, e);
   endtask
   task automatic t_modes;
      logic [5:0] code [7] = '{6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D,
                               6'h1E};
      int         grp [7] = '{1, 2, 4, 8, 1, 2, 4};
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, pixmux_pkg::ADDR_MUX, {24'h0, 2'b11, code[i]});
         apb(1'b1, pixmux_pkg::ADDR_CLKSEL, grp[i]);
         rd(pixmux_pkg::ADDR_STAT,
            (i < 4 ? 1 : 2) | grp[i] << 3 | 8'h80);
         pixel_source_inst.load(32'h87654321, 1'b0, grp[i] + 1, 3);
         pal_seq(32'h87654321, grp[i],
                 i < 4 ? 4 : 8);
      end
      // A code outside the table selects no mode and emits nothing.
      apb(1'b1, pixmux_pkg::ADDR_MUX, 32'h10);
      rd(pixmux_pkg::ADDR_STAT, 32'h05);
      pixel_source_inst.load(32'h87654321, 1'b0, 2, 3);
      pal_seq(32'h0, 0, 8);
   endtask
   task automatic t_nibble;
      apb(1'b1, pixmux_pkg::ADDR_MUX, 32'h1F);
      pixel_source_inst.load(32'h87654321, 1'b0, 4, 5);
      pal_seq(32'h7531, 4, 4);
      apb(1'b1, pixmux_pkg::ADDR_MUX, 32'h1C);
      apb(1'b1, pixmux_pkg::ADDR_GEN, 32'h08);
      rd(pixmux_pkg::ADDR_STAT, 32'hA3);
      pixel_source_inst.load(32'h87654321, 1'b1, 4, 3);
      pal_seq(32'h8642, 4, 4);
      apb(1'b1, pixmux_pkg::ADDR_GEN, 32'h0C);
      pixel_source_inst.load(32'h87654321, 1'b1, 1, 3);
      pal_seq(32'h21, 1, 8);
   endtask
   // One true-colour load under a given read mask.
   task automatic tc_one(input logic [31:0] d, input logic [7:0] m);
      apb(1'b1, pixmux_pkg::ADDR_MASK, {24'h0, m});
      pixel_source_inst.load(d, 1'b0, 2, 3);
      chk("count", 1, seen.size());
      chk("dac", {1'b1, d[15:8], d[23:16], d[31:24], |d[7:0] && |m,
                  d[7:0] & m}, seen[0][33:0]);
      seen.delete();
   endtask
   task automatic t_true;
      apb(1'b1, pixmux_pkg::ADDR_MUX, {26'h0, pixmux_pkg::CODE_TC_E});
      tc_one(32'hAABBCC5A, 8'hFF);
      tc_one(32'h11223300, 8'hFF);
      apb(1'b1, pixmux_pkg::ADDR_MUX, {26'h0, pixmux_pkg::CODE_TC_F});
      tc_one(32'h4455665A, 8'h00);
      pixel_source_inst.vga(8'h77);
      pal_seq(32'h0, 0, 8);
   endtask
   task automatic t_restore;
      apb(1'b1, pixmux_pkg::ADDR_GEN, 32'h08);
      apb(1'b1, pixmux_pkg::ADDR_CLKSEL, 32'h04);
      apb(1'b1, pixmux_pkg::ADDR_MASK, 32'h0F);
      apb(1'b1, pixmux_pkg::ADDR_MUX, 32'h2D);
      rd(pixmux_pkg::ADDR_GEN, 32'h00);
      rd(pixmux_pkg::ADDR_CLKSEL, 32'h01);
      rd(pixmux_pkg::ADDR_MASK, 32'hFF);
      pixel_source_inst.vga(8'h3C);
      pal_seq(32'h3C, 1, 8);
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Watchdog against a hung sequence.
   initial begin
      #300000;
      err_count++;
      complete_run;
   end
   // Main sequence.
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_modes;
      t_nibble;
      t_true;
      t_restore;
      complete_run;
   end
endmodule
`default_nettype wire
